// *** hdl/cms_map.svh ***
`ifndef CMS_MAP_SVH
`define CMS_MAP_SVH
// Clock and tick timebase
`define CMS_CLK_KHZ 125000
`define CMS_TICK_MS 10
// Times in their own units
`define CMS_DEB_MS 30
`define CMS_HALF_S_MS 500
`define CMS_TWO_S_MS 2000
`define CMS_FLASH_MS 200
`define CMS_FLASH_CNT 5
`define CMS_SEQ_MS 2000
`define CMS_IDLE_H 24
`define CMS_EQ_H 1
`define CMS_WEEK_D 7
`define CMS_ABS_MIN_MIN 30
// Voltages in mV, cell counts per battery
`define CMS_CELL_STORE_MV 2200
`define CMS_CELLS_12V 6
`define CMS_CELLS_24V 12
`define CMS_EQ_ADD12_MV 1000
`define CMS_EQ_ADD24_MV 2000
// Register byte offsets
`define CMS_REG_CTRL 8'h00
`define CMS_REG_ABSMAX 8'h04
`define CMS_REG_ABSMV 8'h08
`define CMS_REG_FLTMV 8'h0C
`define CMS_REG_SLEW 8'h10
`define CMS_REG_STAT 8'h14
`define CMS_REG_VSET 8'h18
// Field positions
`define CMS_CTRL_EN 0
`define CMS_CTRL_B24 1
// Reset values
`define CMS_CTRL_RST 2'h1
`define CMS_ABSMAX_RST 32'h0015F900
`define CMS_ABSMV_RST 16'h3840
`define CMS_FLTMV_RST 16'h35E8
`define CMS_SLEW_RST 16'h0001
`endif

// *** hdl/cms_pkg.sv ***
package cms_pkg;
  typedef enum logic [1:0] {POS_OFF, POS_ON, POS_CHG} cms_pos_t;
  typedef enum logic [2:0] {
    ST_BULK, ST_ABS, ST_FLOAT, ST_STORE, ST_REFRESH, ST_EQUAL, ST_FORCE
  } cms_stage_t;
  typedef enum logic [2:0] {
    G_IDLE, G_ARM, G_C1, G_O2, G_FLASH, G_SEQ
  } cms_gest_t;
endpackage

// *** hdl/cms_charger_mode_selector.sv ***
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "cms_map.svh"
// Operation
// - Stages run bulk, absorption, float, storage in order; one at a time.
// - Absorption length follows discharge depth: short after light, long after deep.
// - Storage after 24 hours without discharge; a discharge restarts the period.
// - Storage setpoint is 2.2 V per cell, 13.2 V on 12 V.
// - Weekly, storage raises setpoint to absorption level, then returns.
// - Above gassing voltage the setpoint rise rate is limited.
// - Switch on without mains runs inverter and lights inverter indicator.
// - Accepted mains passes through, stops inverter, charges, lights mains and stage.
// - Switch on and mains rejected turns the inverter on.
// - Charger-only runs charger with pass-through, never the inverter.
// - Equalise one hour, 1 V or 2 V above absorption, quarter current.
// - Equalise flashes bulk and absorption indicators alternately.
// - Forced absorption holds absorption voltage for maximum time, absorption lit.
// - Mode entry only when all switches on, none in charger-only.
// - Off seen during gesture restarts the detector from its first step.
// - Recognised gesture flashes three indicators five times, mirrored on remote.
// - Then bulk, absorption, float indicators light in turn, two seconds each.
// - Return to on picks equalise, forced absorption, or float after sequence.
// - Switch left alone keeps charger-only and sets stage to float.
// - One quick switch change after selection leaves the stage alone.
module cms_charger_mode_selector #(
  parameter int TICK_CYC = `CMS_TICK_MS * `CMS_CLK_KHZ,
  parameter int IDLE_TK = `CMS_IDLE_H * 3600 * 1000 / `CMS_TICK_MS,
  parameter int WEEK_TK = `CMS_WEEK_D * 24 * 3600 * 1000 / `CMS_TICK_MS,
  parameter int EQ_TK = `CMS_EQ_H * 3600 * 1000 / `CMS_TICK_MS,
  parameter int ABS_MIN_TK = `CMS_ABS_MIN_MIN * 60 * 1000 / `CMS_TICK_MS
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic front_on,
  input wire logic front_chg,
  input wire logic rem_on,
  input wire logic rem_chg,
  input wire logic rem_present,
  input wire logic mains_ok,
  input wire logic bat_discharge,
  input wire logic bat_gassing,
  input wire logic bulk_done,
  output logic inv_on,
  output logic pass_on,
  output logic chg_on,
  output logic led_inverter,
  output logic led_mains,
  output logic led_bulk,
  output logic led_abs,
  output logic led_float,
  output logic rem_led_bulk,
  output logic rem_led_abs,
  output logic rem_led_float,
  output logic [15:0] vset_mv,
  output logic cur_quarter,
  output cms_pkg::cms_stage_t stage_o
);
  import cms_pkg::*;

  localparam int DEB_TK = `CMS_DEB_MS / `CMS_TICK_MS;
  localparam int HALF_TK = (`CMS_HALF_S_MS + `CMS_TICK_MS - 1) / `CMS_TICK_MS;
  localparam int TWO_TK = `CMS_TWO_S_MS / `CMS_TICK_MS;
  localparam int FLASH_TK = `CMS_FLASH_MS / `CMS_TICK_MS;
  localparam int SEQ_TK = `CMS_SEQ_MS / `CMS_TICK_MS;

  // Tick divider
  logic [31:0] div_reg;
  logic tick;
  assign tick = (div_reg == 32'(TICK_CYC - 1));
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) div_reg <= 32'h0;
    else div_reg <= tick ? 32'h0 : div_reg + 32'h1;
  end

  // Debounce of the four raw switch contacts
  logic [3:0] raw;
  logic [3:0] deb_reg;
  assign raw = {rem_chg, rem_on, front_chg, front_on};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_deb
      logic [7:0] cnt_reg;
      logic q_reg;
      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          cnt_reg <= 8'h0;
          q_reg <= 1'b0;
        end else if (raw[gi] == q_reg) begin
          cnt_reg <= 8'h0;
        end else if (tick) begin
          if (cnt_reg == 8'(DEB_TK - 1)) begin
            q_reg <= raw[gi];
            cnt_reg <= 8'h0;
          end else begin
            cnt_reg <= cnt_reg + 8'h1;
          end
        end
      end
      // Each contact keeps its own flop so no vector is written by several processes
      assign deb_reg[gi] = q_reg;
    end
  endgenerate

  // Combined position: any off wins, then any charger-only
  wire f_off = !deb_reg[0] && !deb_reg[1];
  wire r_off = rem_present && !deb_reg[2] && !deb_reg[3];
  wire f_chg = deb_reg[1];
  wire r_chg = rem_present && deb_reg[3];
  cms_pos_t pos;
  assign pos = (f_off || r_off) ? POS_OFF :
               (f_chg || r_chg) ? POS_CHG : POS_ON;

  // Register file
  logic [1:0] ctrl_reg;
  logic [31:0] absmax_reg;
  logic [15:0] absmv_reg;
  logic [15:0] fltmv_reg;
  logic [15:0] slew_reg;
  logic [31:0] mask;
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wb_wr = wb_req && wb_we_i;
  assign mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] wmix_ctrl = ({30'h0, ctrl_reg} & ~mask) | (wb_dat_i & mask);
  wire [31:0] wmix_absmax = (absmax_reg & ~mask) | (wb_dat_i & mask);
  wire [31:0] wmix_absmv = ({16'h0, absmv_reg} & ~mask) | (wb_dat_i & mask);
  wire [31:0] wmix_fltmv = ({16'h0, fltmv_reg} & ~mask) | (wb_dat_i & mask);
  wire [31:0] wmix_slew = ({16'h0, slew_reg} & ~mask) | (wb_dat_i & mask);
  wire chg_en = ctrl_reg[`CMS_CTRL_EN];
  wire bat24 = ctrl_reg[`CMS_CTRL_B24];

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= `CMS_CTRL_RST;
      absmax_reg <= `CMS_ABSMAX_RST;
      absmv_reg <= `CMS_ABSMV_RST;
      fltmv_reg <= `CMS_FLTMV_RST;
      slew_reg <= `CMS_SLEW_RST;
    end else if (wb_wr) begin
      case (wb_adr_i)
        `CMS_REG_CTRL: ctrl_reg <= wmix_ctrl[1:0];
        `CMS_REG_ABSMAX: absmax_reg <= wmix_absmax;
        `CMS_REG_ABSMV: absmv_reg <= wmix_absmv[15:0];
        `CMS_REG_FLTMV: fltmv_reg <= wmix_fltmv[15:0];
        `CMS_REG_SLEW: slew_reg <= wmix_slew[15:0];
        default: ;
      endcase
    end
  end

  // Gesture detector
  cms_gest_t g_reg;
  logic [15:0] gt_reg;
  logic [3:0] fl_reg;
  logic [1:0] sidx_reg;
  logic gsel_reg;
  cms_stage_t gmode_reg;
  cms_stage_t stage_reg;
  wire gt_half = gt_reg >= 16'(HALF_TK);
  wire gt_two = gt_reg > 16'(TWO_TK);
  wire gt_inc = tick;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      g_reg <= G_IDLE;
      gt_reg <= 16'h0;
      fl_reg <= 4'h0;
      sidx_reg <= 2'h0;
      gsel_reg <= 1'b0;
      gmode_reg <= ST_FLOAT;
    end else begin
      gsel_reg <= 1'b0;
      if (gt_inc) gt_reg <= gt_reg + 16'h1;
      if (pos == POS_OFF) begin
        g_reg <= G_IDLE;
      end else begin
        unique case (g_reg)
          G_IDLE: if (pos == POS_ON) g_reg <= G_ARM;
          G_ARM: if (pos == POS_CHG) begin
            g_reg <= G_C1;
            gt_reg <= 16'h0;
          end
          G_C1: begin
            if (pos == POS_ON) begin
              g_reg <= gt_half ? G_O2 : G_ARM;
              gt_reg <= 16'h0;
            end else if (gt_two) begin
              g_reg <= G_IDLE;
            end
          end
          G_O2: begin
            if (pos == POS_CHG) begin
              g_reg <= gt_half ? G_FLASH : G_C1;
              gt_reg <= 16'h0;
              fl_reg <= 4'h0;
            end else if (gt_two) begin
              g_reg <= G_ARM;
            end
          end
          G_FLASH: if (gt_inc && gt_reg == 16'(FLASH_TK - 1)) begin
            gt_reg <= 16'h0;
            fl_reg <= fl_reg + 4'h1;
            if (fl_reg == 4'(2 * `CMS_FLASH_CNT - 1)) begin
              g_reg <= G_SEQ;
              sidx_reg <= 2'h0;
            end
          end
          G_SEQ: begin
            if (pos == POS_ON || sidx_reg == 2'h3) begin
              g_reg <= G_IDLE;
              gsel_reg <= 1'b1;
              unique case (sidx_reg)
                2'h0: gmode_reg <= ST_EQUAL;
                2'h1: gmode_reg <= ST_FORCE;
                default: gmode_reg <= ST_FLOAT;
              endcase
            end else if (gt_inc && gt_reg == 16'(SEQ_TK - 1)) begin
              gt_reg <= 16'h0;
              sidx_reg <= sidx_reg + 2'h1;
            end
          end
        endcase
      end
    end
  end

  // Charge stage machine
  logic [31:0] st_tmr_reg;
  logic [31:0] bulk_len_reg;
  logic [31:0] idle_reg;
  logic [31:0] week_reg;
  logic [31:0] abs_len;
  wire chg_act = mains_ok && pos != POS_OFF && chg_en;
  // Bulk duration stands in for discharge depth
  assign abs_len = (bulk_len_reg < 32'(ABS_MIN_TK)) ? 32'(ABS_MIN_TK) :
                   (bulk_len_reg > absmax_reg) ? absmax_reg : bulk_len_reg;
  wire abs_end = st_tmr_reg >= abs_len;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idle_reg <= 32'h0;
      week_reg <= 32'h0;
    end else begin
      if (bat_discharge) idle_reg <= 32'h0;
      else if (tick && idle_reg != 32'hFFFFFFFF) idle_reg <= idle_reg + 32'h1;
      if (stage_reg != ST_STORE) week_reg <= 32'h0;
      else if (tick) week_reg <= week_reg + 32'h1;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage_reg <= ST_BULK;
      st_tmr_reg <= 32'h0;
      bulk_len_reg <= 32'h0;
    end else if (!chg_act) begin
      stage_reg <= ST_BULK;
      st_tmr_reg <= 32'h0;
    end else if (gsel_reg) begin
      stage_reg <= gmode_reg;
      st_tmr_reg <= 32'h0;
    end else begin
      if (tick) st_tmr_reg <= st_tmr_reg + 32'h1;
      unique case (stage_reg)
        ST_BULK: if (bulk_done) begin
          stage_reg <= ST_ABS;
          bulk_len_reg <= st_tmr_reg;
          st_tmr_reg <= 32'h0;
        end
        ST_ABS: if (abs_end) stage_reg <= ST_FLOAT;
        ST_FLOAT: if (idle_reg >= 32'(IDLE_TK)) stage_reg <= ST_STORE;
        ST_STORE: begin
          if (bat_discharge) begin
            stage_reg <= ST_FLOAT;
          end else if (week_reg >= 32'(WEEK_TK)) begin
            stage_reg <= ST_REFRESH;
            st_tmr_reg <= 32'h0;
          end
        end
        ST_REFRESH: if (abs_end) stage_reg <= ST_STORE;
        ST_EQUAL: if (st_tmr_reg >= 32'(EQ_TK)) stage_reg <= ST_FLOAT;
        ST_FORCE: if (st_tmr_reg >= absmax_reg) stage_reg <= ST_FLOAT;
        default: stage_reg <= ST_BULK;
      endcase
    end
  end

  // Voltage setpoint
  logic [15:0] tgt_mv;
  wire [15:0] store_mv = 16'(`CMS_CELL_STORE_MV * (bat24 ? `CMS_CELLS_24V : `CMS_CELLS_12V));
  wire [15:0] eq_add = bat24 ? 16'(`CMS_EQ_ADD24_MV) : 16'(`CMS_EQ_ADD12_MV);
  always_comb begin
    unique case (stage_reg)
      ST_FLOAT: tgt_mv = fltmv_reg;
      ST_STORE: tgt_mv = store_mv;
      ST_EQUAL: tgt_mv = absmv_reg + eq_add;
      default: tgt_mv = absmv_reg;
    endcase
  end
  wire [16:0] ramp = {1'b0, vset_mv} + {1'b0, slew_reg};
  wire ramp_lim = bat_gassing && vset_mv < tgt_mv;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) vset_mv <= 16'h0;
    else if (!ramp_lim) vset_mv <= tgt_mv;
    else if (tick) vset_mv <= (ramp > {1'b0, tgt_mv}) ? tgt_mv : ramp[15:0];
  end

  // Blink source for the equalise indication
  logic [15:0] bl_tmr_reg;
  logic blink_reg;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bl_tmr_reg <= 16'h0;
      blink_reg <= 1'b0;
    end else if (tick) begin
      bl_tmr_reg <= (bl_tmr_reg == 16'(FLASH_TK - 1)) ? 16'h0 : bl_tmr_reg + 16'h1;
      if (bl_tmr_reg == 16'(FLASH_TK - 1)) blink_reg <= !blink_reg;
    end
  end

  // Indicator selection; gesture feedback overrides stage display
  logic [2:0] led_next;
  wire fl_on = !fl_reg[0];
  always_comb begin
    led_next = 3'b000;
    if (g_reg == G_FLASH) begin
      led_next = {3{fl_on}};
    end else if (g_reg == G_SEQ) begin
      led_next = (sidx_reg == 2'h0) ? 3'b001 :
                 (sidx_reg == 2'h1) ? 3'b010 :
                 (sidx_reg == 2'h2) ? 3'b100 : 3'b000;
    end else if (chg_act) begin
      unique case (stage_reg)
        ST_BULK: led_next = 3'b001;
        ST_ABS, ST_REFRESH, ST_FORCE: led_next = 3'b010;
        ST_EQUAL: led_next = blink_reg ? 3'b010 : 3'b001;
        default: led_next = 3'b100;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      inv_on <= 1'b0;
      pass_on <= 1'b0;
      chg_on <= 1'b0;
      led_inverter <= 1'b0;
      led_mains <= 1'b0;
      {led_float, led_abs, led_bulk} <= 3'b000;
      {rem_led_float, rem_led_abs, rem_led_bulk} <= 3'b000;
      cur_quarter <= 1'b0;
    end else begin
      inv_on <= pos == POS_ON && !mains_ok;
      pass_on <= pos != POS_OFF && mains_ok;
      chg_on <= chg_act;
      led_inverter <= pos == POS_ON && !mains_ok;
      led_mains <= pos != POS_OFF && mains_ok;
      {led_float, led_abs, led_bulk} <= led_next;
      {rem_led_float, rem_led_abs, rem_led_bulk} <= led_next;
      cur_quarter <= chg_act && stage_reg == ST_EQUAL;
    end
  end
  assign stage_o = stage_reg;

  // Wishbone read path and acknowledge
  logic [31:0] rd_mux;
  wire [31:0] stat_word = {21'h0, g_reg, stage_reg, pos, chg_on, pass_on, inv_on};
  assign rd_mux = (wb_adr_i == `CMS_REG_CTRL) ? {30'h0, ctrl_reg} :
                  (wb_adr_i == `CMS_REG_ABSMAX) ? absmax_reg :
                  (wb_adr_i == `CMS_REG_ABSMV) ? {16'h0, absmv_reg} :
                  (wb_adr_i == `CMS_REG_FLTMV) ? {16'h0, fltmv_reg} :
                  (wb_adr_i == `CMS_REG_SLEW) ? {16'h0, slew_reg} :
                  (wb_adr_i == `CMS_REG_STAT) ? stat_word :
                  (wb_adr_i == `CMS_REG_VSET) ? {16'h0, vset_mv} : 32'h0;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) wb_dat_o <= rd_mux;
    end
  end
endmodule // cms_charger_mode_selector

// *** test/cms_switch_model.sv ***
`timescale 1ns/1ps
module cms_switch_model (
  input wire logic ref_clk,
  input wire cms_pkg::cms_pos_t pos,
  output logic sw_on,
  output logic sw_chg
);
  import cms_pkg::*;
  // Lever snaps between on and charger-only; off is never crossed on the way
  always_ff @(posedge ref_clk) begin
    sw_on <= pos == POS_ON;
    sw_chg <= pos == POS_CHG;
  end
endmodule // cms_switch_model

// *** test/cms_chk.sv ***
`timescale 1ns/1ps
module cms_chk #(
  parameter int TICK_CYC = 4
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic front_on,
  input wire logic front_chg,
  input wire logic rem_present,
  input wire logic inv_on,
  input wire logic pass_on,
  input wire logic led_inverter,
  input wire logic led_mains,
  input wire logic led_bulk,
  input wire logic led_abs,
  input wire logic [15:0] vset_mv,
  input wire logic cur_quarter,
  input wire cms_pkg::cms_stage_t stage_o
);
  import cms_pkg::*;
  logic [15:0] chg_cnt_reg;
  logic [15:0] chg_cnt_next;
  wire chg_held = front_chg && !front_on && !rem_present;
  // Saturate so a long charger-only spell never wraps back below the bound
  assign chg_cnt_next = !chg_held ? 16'h0000 : (chg_cnt_reg == 16'hFFFF ? chg_cnt_reg : chg_cnt_reg + 16'h0001);
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      chg_cnt_reg <= 16'h0000;
    end else begin
      chg_cnt_reg <= chg_cnt_next;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_inv_pass_excl: assert property (!(inv_on && pass_on))
    else $error("inverter runs during pass-through");
  chk_inv_led: assert property (inv_on |-> led_inverter)
    else $error("inverter indicator dark");
  chk_mains_led: assert property (pass_on |-> led_mains)
    else $error("mains indicator dark");
  chk_chg_no_inv: assert property (chg_cnt_reg > 5 * TICK_CYC |-> !inv_on)
    else $error("inverter on in charger-only");
  chk_store_entry: assert property (stage_o == ST_STORE && $past(stage_o) != ST_STORE
    |-> $past(stage_o) inside {ST_FLOAT, ST_REFRESH})
    else $error("storage entered out of order");
  chk_store_vset: assert property (stage_o == ST_STORE && $past(stage_o) == ST_STORE
    |-> vset_mv inside {16'd13200, 16'd26400})
    else $error("storage setpoint wrong");
  chk_eq_quarter: assert property (stage_o == ST_EQUAL && $past(stage_o) == ST_EQUAL |-> cur_quarter)
    else $error("equalise current not limited");
  chk_eq_alt_leds: assert property (stage_o == ST_EQUAL && $past(stage_o) == ST_EQUAL |-> led_bulk != led_abs)
    else $error("equalise indicators not alternating");
  chk_force_led: assert property (stage_o == ST_FORCE && $past(stage_o) == ST_FORCE |-> led_abs && !led_bulk)
    else $error("forced absorption indicator wrong");
endmodule // cms_chk
bind cms_charger_mode_selector cms_chk #(.TICK_CYC(TICK_CYC)) u_chk (.*);

// *** test/tb_charger_mode_selector.sv ***
`timescale 1ns/1ps
`include "cms_map.svh"
module tb_charger_mode_selector;
  import cms_pkg::*;
  localparam int TK = 4;
  logic ref_clk = 0;
  logic sys_rst = 1;
  logic [7:0] wb_adr_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
  logic [3:0] wb_sel_i = 0;
  logic wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_ack_o;
  logic front_on, front_chg, rem_on, rem_chg, inv_on, pass_on, chg_on, led_inverter, led_mains;
  logic rem_present = 0, mains_ok = 0, bat_discharge = 0, bat_gassing = 0, bulk_done = 0;
  logic led_bulk, led_abs, led_float, rem_led_bulk, rem_led_abs, rem_led_float, cur_quarter;
  logic [15:0] vset_mv;
  cms_stage_t stage_o;
  cms_pos_t fpos = POS_OFF, rpos = POS_OFF;
  int bad_count = 0, check_count = 0;
  always #4 ref_clk = ~ref_clk;
  cms_charger_mode_selector #(.TICK_CYC(TK), .IDLE_TK(50), .WEEK_TK(80), .EQ_TK(30), .ABS_MIN_TK(5)) uut (.*);
  cms_switch_model u_front (.ref_clk(ref_clk), .pos(fpos), .sw_on(front_on), .sw_chg(front_chg));
  cms_switch_model u_rem (.ref_clk(ref_clk), .pos(rpos), .sw_on(rem_on), .sw_chg(rem_chg));
  task give_verdict;
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tk(input int n);
    repeat (n * TK) @(posedge ref_clk);
  endtask
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      give_verdict();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask
  task wait_stage(input cms_stage_t s, input int lim);
    int n;
    n = 0;
    while (stage_o !== s && n < lim * TK) begin
      @(posedge ref_clk);
      n++;
    end
    if (stage_o !== s) begin
      bad_count++;
      give_verdict();
    end
  endtask
  task regs;
    logic [7:0] ra [6];
    logic [31:0] rv [6];
    ra = '{`CMS_REG_CTRL, `CMS_REG_ABSMAX, `CMS_REG_ABSMV, `CMS_REG_FLTMV, `CMS_REG_SLEW, 8'h1C};
    rv = '{`CMS_CTRL_RST, `CMS_ABSMAX_RST, `CMS_ABSMV_RST, `CMS_FLTMV_RST, `CMS_SLEW_RST, 32'h0};
    foreach (ra[i]) begin
      bus(ra[i], 1'b0, 32'h0);
      check(rd, rv[i]);
    end
    bus(`CMS_REG_ABSMAX, 1'b1, 32'h14);
    bus(`CMS_REG_ABSMAX, 1'b0, 32'h0);
    check(rd, 32'h14);
    bus(`CMS_REG_VSET, 1'b1, 32'h0);
    bus(`CMS_REG_VSET, 1'b0, 32'h0);
    check(rd, `CMS_ABSMV_RST);
  endtask
  task power;
    fpos <= POS_ON;
    tk(6);
    check({inv_on, led_inverter}, 2'b11);
    mains_ok <= 1;
    tk(2);
    check({inv_on, pass_on, chg_on, led_mains, led_bulk}, 5'b01111);
    fpos <= POS_CHG;
    mains_ok <= 0;
    tk(8);
    check(inv_on, 1'b0);
    mains_ok <= 1;
    tk(2);
    check({inv_on, pass_on, chg_on}, 3'b011);
    fpos <= POS_ON;
    tk(4);
  endtask
  task cycle(input int bulk_tk, input int lo, input int hi);
    int n;
    mains_ok <= 0;
    tk(1);
    mains_ok <= 1;
    bulk_done <= 0;
    tk(bulk_tk);
    bulk_done <= 1;
    wait_stage(ST_ABS, 5);
    n = 0;
    while (stage_o === ST_ABS && n < 100 * TK) begin
      @(posedge ref_clk);
      n++;
    end
    check(n / TK >= lo && n / TK <= hi, 1'b1);
    check(stage_o, ST_FLOAT);
  endtask
  task storage;
    tk(40);
    bat_discharge <= 1;
    tk(1);
    bat_discharge <= 0;
    tk(40);
    check(stage_o, ST_FLOAT);
    wait_stage(ST_STORE, 20);
    tk(1);
    check(vset_mv, `CMS_CELL_STORE_MV * `CMS_CELLS_12V);
    wait_stage(ST_REFRESH, 90);
    tk(1);
    check(vset_mv, `CMS_ABSMV_RST);
    wait_stage(ST_STORE, 25);
    bat_gassing <= 1;
    wait_stage(ST_REFRESH, 90);
    tk(2);
    check(vset_mv > 16'd13200 && vset_mv < 16'd13210, 1'b1);
    bat_gassing <= 0;
  endtask
  task gesture(input int sel);
    int n;
    logic a, p;
    // Discharge held so storage never pre-empts the float checks
    bat_discharge <= 1;
    wait_stage(ST_FLOAT, 30);
    fpos <= POS_CHG;
    tk(100);
    fpos <= POS_ON;
    tk(100);
    fpos <= POS_CHG;
    n = 0;
    a = 0;
    while (!a && n < 80 * TK) begin
      @(posedge ref_clk);
      a = led_bulk && led_abs && led_float;
      n++;
    end
    if (!a) begin
      bad_count++;
      give_verdict();
    end
    n = 1;
    p = 1;
    repeat (225 * TK) begin
      @(posedge ref_clk);
      a = led_bulk && led_abs && led_float;
      if (a && !p) n++;
      p = a;
    end
    check(n, 5);
    check({rem_led_bulk, rem_led_abs, rem_led_float}, {led_bulk, led_abs, led_float});
    check({led_bulk, led_abs, led_float}, 3'b100);
    if (sel == 2) begin
      tk(585);
      check({stage_o, chg_on, inv_on}, {ST_FLOAT, 2'b10});
      fpos <= POS_ON;
      tk(10);
      fpos <= POS_CHG;
      tk(6);
      check(stage_o, ST_FLOAT);
    end else begin
      if (sel == 1) tk(200);
      check({led_bulk, led_abs, led_float}, sel ? 3'b010 : 3'b100);
      fpos <= POS_ON;
      wait_stage(sel ? ST_FORCE : ST_EQUAL, 10);
      tk(2);
      check(vset_mv, sel ? `CMS_ABSMV_RST : `CMS_ABSMV_RST + `CMS_EQ_ADD12_MV);
      check(cur_quarter, sel ? 1'b0 : 1'b1);
      tk(15);
      check(stage_o, sel ? ST_FORCE : ST_EQUAL);
      tk(15);
      check(stage_o !== ST_FORCE && stage_o !== ST_EQUAL, 1'b1);
    end
  endtask
  task restart;
    fpos <= POS_CHG;
    tk(100);
    fpos <= POS_ON;
    tk(60);
    // Off in the middle of the gesture must throw the detector back to its start
    fpos <= POS_OFF;
    tk(6);
    fpos <= POS_ON;
    tk(60);
    fpos <= POS_CHG;
    tk(10);
    check({led_bulk, led_abs, led_float}, 3'b001);
    fpos <= POS_ON;
    tk(6);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 0;
    regs();
    power();
    cycle(2, 4, 7);
    cycle(12, 11, 15);
    storage();
    gesture(0);
    gesture(1);
    restart();
    gesture(2);
    give_verdict();
  end
endmodule // tb_charger_mode_selector
